// ---- inc/ulc_pkg.sv ----
// Constants and types for the UART line/FIFO/modem control block
// Contract
// - Enhanced mode: CTS input or RTS output rising sets handshake-change bit; code also needs EF_AUTO_IN for CTS, EF_AUTO_OUT for RTS.
// - Status bits 7:6 read 0 with FIFOs off, 1 with FIFOs on.
// - FIFO enable gates all other FIFO control bits in the same write.
// - Receive FIFO reset clears pointers and count, self-clears.
// - Transmit FIFO reset clears pointers and count, self-clears.
// - Block-transfer mode bit stored only, no functional effect.
// - Transmit request below trigger, or at empty if never filled above; code clears the filled-above mark at any load not above trigger.
// - Transmit trigger field writable only with enhanced mode set.
// - One trigger table governs both directions.
// - Table A: rx 1/4/8/14, tx 1; table B: rx 8/16/24/28, tx 16/8/24/30.
// - Table C: rx 8/16/56/60, tx 8/16/32/56; table D programmable.
// - Receive trigger field resets to 0, level 1.
// - Word length codes give 5 to 8 data bits, reset 5.
// - Stop select: 1 stop, or 1.5 for 5-bit and 2 otherwise.
// - Parity enable adds parity on transmit and checks on receive.
// - Even select 0 odd parity, 1 even parity; code uses even select only for forced parity, PAR_CALC for both senses.
// - Forced parity: bit is 1 when even select 0, else 0.
// - Break bit holds serial output low until cleared.
// - Divisor access bit steers data locations to divisor latches.
// - DTR control bit drives active-low DTR; flow control may override.
// - RTS control bit drives active-low RTS; flow control may override.
// - Pair select routes auto flow control to RTS/CTS or DTR/DSR.
package ulc_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_DIV_HIGH = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;
  localparam logic [3:0] OFS_LINE = 4'h3;
  localparam logic [3:0] OFS_MODEM = 4'h4;
  localparam logic [3:0] OFS_ENH = 4'h5;
  localparam logic [3:0] OFS_TABLE = 4'h6;
  localparam logic [3:0] OFS_PROG_RX = 4'h7;
  localparam logic [3:0] OFS_PROG_TX = 4'h8;
  localparam logic [3:0] OFS_FORMAT = 4'h9;
  // fifo_control fields
  localparam int FC_EN = 0;
  localparam int FC_RXRST = 1;
  localparam int FC_TXRST = 2;
  localparam int FC_MODE = 3;
  localparam int FC_TXT_LO = 4;
  localparam int FC_RXT_LO = 6;
  // line_format_control fields
  localparam int LC_PEN = 3;
  localparam int LC_EVEN = 4;
  localparam int LC_FORCE = 5;
  localparam int LC_BRK = 6;
  localparam int LC_DIV = 7;
  localparam int LC_STOP = 2;
  // modem_output_control fields
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_PAIR = 2;
  // enhanced_feature_reg fields
  localparam int EF_ENH = 4;
  localparam int EF_AUTO_OUT = 6;
  localparam int EF_AUTO_IN = 7;
  localparam int TB_LO = 6;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DIV_LOW = 8'h01;
  localparam logic [7:0] IDLE_STATUS = 8'h01;
  typedef enum logic [1:0] {TBL_A, TBL_B, TBL_C, TBL_D} ulc_table_t;
  typedef enum logic [1:0] {PAR_NONE, PAR_CALC, PAR_MARK, PAR_SPACE}
    ulc_parity_t;
endpackage : ulc_pkg

// ---- src/ulc_top.sv ----
// UART channel FIFO, line format and modem output control
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module ulc_top #(
  parameter int FIFO_DEPTH = 64
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [ulc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // FIFO state from the data path
  input wire logic [6:0] txCount,
  input wire logic txLoad,
  input wire logic rxFlowStop,
  // Modem pins
  input wire logic ctsIn_n,
  input wire logic dsrIn_n,
  output logic dtrOut_n,
  output logic rtsOut_n,
  // Controls to the data path
  input wire logic txShiftData,
  output logic txSerial,
  output logic rxFifoClear,
  output logic txFifoClear,
  output logic fifoEnable,
  output logic txRequest,
  output logic [6:0] rxTrigLevel,
  output logic [6:0] txTrigLevel,
  output logic [3:0] dataBits,
  output logic [2:0] stopHalfBits,
  output logic parityEnable,
  output logic [1:0] parityMode,
  output logic [15:0] baudDivisor
);
  initial begin
    if (FIFO_DEPTH < 64 || FIFO_DEPTH > 127)
      $error("FIFO_DEPTH must be 64 to 127");
  end

  logic [7:0] fifoCtl_reg, lineCtl_reg, modemCtl_reg, enhFeat_reg;
  logic [7:0] divLow_reg, divHigh_reg, progRx_reg, progTx_reg;
  logic [1:0] table_reg;
  logic hsChange_reg, ctsPrev_reg, rtsPrev_reg;
  logic filledAbove_reg, txReq_reg;
  logic wrFifo, wrData, wrDivHigh;
  logic ctsLevel, rtsAutoHigh, rtsLevel;

  assign wrData = regWrite && regAddr == ulc_pkg::OFS_DATA;
  assign wrDivHigh = regWrite && regAddr == ulc_pkg::OFS_DIV_HIGH;
  // Status location writes the FIFO control word, with or without divisor access
  assign wrFifo = regWrite && regAddr == ulc_pkg::OFS_STATUS;

  // Decode of one trigger table entry
  function automatic logic [6:0] trigLevel(input logic [1:0] tbl,
      input logic [1:0] code, input logic isTx, input logic [7:0] prog);
    logic [6:0] lvl;
    lvl = 7'h01;
    case (ulc_pkg::ulc_table_t'(tbl))
      ulc_pkg::TBL_A:
        lvl = isTx ? 7'h01 : (code == 2'h0 ? 7'h01 : code == 2'h1 ? 7'h04 :
          code == 2'h2 ? 7'h08 : 7'h0e);
      ulc_pkg::TBL_B:
        lvl = isTx ? (code == 2'h0 ? 7'h10 : code == 2'h1 ? 7'h08 :
          code == 2'h2 ? 7'h18 : 7'h1e) : (code == 2'h0 ? 7'h08 :
          code == 2'h1 ? 7'h10 : code == 2'h2 ? 7'h18 : 7'h1c);
      ulc_pkg::TBL_C:
        lvl = isTx ? (code == 2'h0 ? 7'h08 : code == 2'h1 ? 7'h10 :
          code == 2'h2 ? 7'h20 : 7'h38) : (code == 2'h0 ? 7'h08 :
          code == 2'h1 ? 7'h10 : code == 2'h2 ? 7'h38 : 7'h3c);
      ulc_pkg::TBL_D:
        lvl = prog[6:0];
      default: lvl = 7'h01;
    endcase
    return lvl;
  endfunction : trigLevel

  // Other bits only with enable in same write
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      fifoCtl_reg <= ulc_pkg::RST_ZERO;
    end else if (wrFifo) begin
      fifoCtl_reg[ulc_pkg::FC_EN] <= regWrData[ulc_pkg::FC_EN];
      if (regWrData[ulc_pkg::FC_EN]) begin
        fifoCtl_reg[ulc_pkg::FC_MODE] <= regWrData[ulc_pkg::FC_MODE];
        fifoCtl_reg[ulc_pkg::FC_RXT_LO +: 2] <=
          regWrData[ulc_pkg::FC_RXT_LO +: 2];
        if (enhFeat_reg[ulc_pkg::EF_ENH])
          fifoCtl_reg[ulc_pkg::FC_TXT_LO +: 2] <=
            regWrData[ulc_pkg::FC_TXT_LO +: 2];
      end
    end
  end

  // Receive and transmit FIFO reset pulses, never stored
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rxFifoClear <= 1'b0;
      txFifoClear <= 1'b0;
    end else begin
      rxFifoClear <= wrFifo && regWrData[ulc_pkg::FC_EN] &&
        regWrData[ulc_pkg::FC_RXRST];
      txFifoClear <= wrFifo && regWrData[ulc_pkg::FC_EN] &&
        regWrData[ulc_pkg::FC_TXRST];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      lineCtl_reg <= ulc_pkg::RST_ZERO;
      modemCtl_reg <= ulc_pkg::RST_ZERO;
      enhFeat_reg <= ulc_pkg::RST_ZERO;
      table_reg <= 2'h0;
      progRx_reg <= ulc_pkg::RST_DIV_LOW;
      progTx_reg <= ulc_pkg::RST_DIV_LOW;
    end else if (regWrite) begin
      case (regAddr)
        ulc_pkg::OFS_LINE: lineCtl_reg <= regWrData;
        ulc_pkg::OFS_MODEM: modemCtl_reg <= regWrData;
        ulc_pkg::OFS_ENH: enhFeat_reg <= regWrData;
        // Last table selection applies to both sides
        ulc_pkg::OFS_TABLE: table_reg <= regWrData[ulc_pkg::TB_LO +: 2];
        ulc_pkg::OFS_PROG_RX: progRx_reg <= regWrData;
        ulc_pkg::OFS_PROG_TX: progTx_reg <= regWrData;
        default: ;
      endcase
    end
  end

  // Divisor latches behind the data locations
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      divLow_reg <= ulc_pkg::RST_DIV_LOW;
      divHigh_reg <= ulc_pkg::RST_ZERO;
    end else begin
      if (wrData && lineCtl_reg[ulc_pkg::LC_DIV])
        divLow_reg <= regWrData;
      if (wrDivHigh && lineCtl_reg[ulc_pkg::LC_DIV])
        divHigh_reg <= regWrData;
    end
  end

  assign fifoEnable = fifoCtl_reg[ulc_pkg::FC_EN];
  assign rxTrigLevel = trigLevel(table_reg,
    fifoCtl_reg[ulc_pkg::FC_RXT_LO +: 2], 1'b0, progRx_reg);
  assign txTrigLevel = trigLevel(table_reg,
    fifoCtl_reg[ulc_pkg::FC_TXT_LO +: 2], 1'b1, progTx_reg);

  // Transmit request by level or by empty
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      filledAbove_reg <= 1'b0;
      txReq_reg <= 1'b0;
    end else begin
      if (txLoad)
        filledAbove_reg <= txCount > txTrigLevel;
      txReq_reg <= filledAbove_reg ? txCount < txTrigLevel
        : txCount == 7'h00;
    end
  end
  assign txRequest = txReq_reg;

  assign dataBits = 4'h5 + {2'h0, lineCtl_reg[1:0]};
  assign stopHalfBits = !lineCtl_reg[ulc_pkg::LC_STOP] ? 3'h2 :
    (lineCtl_reg[1:0] == 2'h0 ? 3'h3 : 3'h4);
  assign parityEnable = lineCtl_reg[ulc_pkg::LC_PEN];
  // Calculated parity without odd/even choice, forced mark or space
  assign parityMode = !lineCtl_reg[ulc_pkg::LC_PEN] ? ulc_pkg::PAR_NONE :
    !lineCtl_reg[ulc_pkg::LC_FORCE] ? ulc_pkg::PAR_CALC :
    (lineCtl_reg[ulc_pkg::LC_EVEN] ? ulc_pkg::PAR_SPACE : ulc_pkg::PAR_MARK);
  assign txSerial = txShiftData && !lineCtl_reg[ulc_pkg::LC_BRK];
  assign baudDivisor = {divHigh_reg, divLow_reg};

  // Auto flow control onto the selected pair
  assign rtsAutoHigh = enhFeat_reg[ulc_pkg::EF_AUTO_OUT] && rxFlowStop;
  assign dtrOut_n = !modemCtl_reg[ulc_pkg::MC_DTR] ||
    (rtsAutoHigh && modemCtl_reg[ulc_pkg::MC_PAIR]);
  assign rtsOut_n = !modemCtl_reg[ulc_pkg::MC_RTS] ||
    (rtsAutoHigh && !modemCtl_reg[ulc_pkg::MC_PAIR]);
  assign ctsLevel = modemCtl_reg[ulc_pkg::MC_PAIR] ? dsrIn_n : ctsIn_n;
  assign rtsLevel = modemCtl_reg[ulc_pkg::MC_PAIR] ? dtrOut_n : rtsOut_n;

  // Rising handshake pin sets change bit; set beats read clear
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctsPrev_reg <= 1'b0;
      rtsPrev_reg <= 1'b1;
      hsChange_reg <= 1'b0;
    end else begin
      ctsPrev_reg <= ctsLevel;
      rtsPrev_reg <= rtsLevel;
      if (enhFeat_reg[ulc_pkg::EF_ENH] && ((ctsLevel && !ctsPrev_reg &&
          enhFeat_reg[ulc_pkg::EF_AUTO_IN]) || (rtsLevel && !rtsPrev_reg &&
          enhFeat_reg[ulc_pkg::EF_AUTO_OUT])))
        hsChange_reg <= 1'b1;
      else if (regRead && regAddr == ulc_pkg::OFS_STATUS)
        hsChange_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      regRdData <= ulc_pkg::RST_ZERO;
    end else if (regRead) begin
      case (regAddr)
        ulc_pkg::OFS_DATA: regRdData <= lineCtl_reg[ulc_pkg::LC_DIV] ?
          divLow_reg : ulc_pkg::RST_ZERO;
        ulc_pkg::OFS_DIV_HIGH: regRdData <= lineCtl_reg[ulc_pkg::LC_DIV] ?
          divHigh_reg : ulc_pkg::RST_ZERO;
        ulc_pkg::OFS_STATUS: regRdData <= {{2{fifoEnable}},
          hsChange_reg, 4'h0, !hsChange_reg};
        ulc_pkg::OFS_LINE: regRdData <= lineCtl_reg;
        ulc_pkg::OFS_MODEM: regRdData <= modemCtl_reg;
        ulc_pkg::OFS_ENH: regRdData <= enhFeat_reg;
        ulc_pkg::OFS_TABLE: regRdData <= {table_reg, 6'h00};
        ulc_pkg::OFS_PROG_RX: regRdData <= progRx_reg;
        ulc_pkg::OFS_PROG_TX: regRdData <= progTx_reg;
        ulc_pkg::OFS_FORMAT: regRdData <= fifoCtl_reg;
        default: regRdData <= ulc_pkg::RST_ZERO;
      endcase
    end else begin
      regRdData <= ulc_pkg::RST_ZERO;
    end
  end
endmodule : ulc_top

// ---- tb/test_uart_fifo_line_modem_control.sv ----
// Self-checking bench for the UART control block
`timescale 1ns/100ps
module test_uart_fifo_line_modem_control;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ulc_pkg::ADDR_W-1:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [6:0] txCount = 7'h00;
  logic txLoad = 1'b0;
  logic rxFlowStop = 1'b0;
  logic ctsLevel = 1'b0;
  logic txShiftData = 1'b1;
  logic ctsIn_n, dsrIn_n, dtrOut_n, rtsOut_n, txSerial, rxFifoClear;
  logic txFifoClear, fifoEnable, txRequest, parityEnable;
  logic [7:0] regRdData, d;
  logic [6:0] rxTrigLevel, txTrigLevel;
  logic [3:0] dataBits;
  logic [2:0] stopHalfBits;
  logic [1:0] parityMode;
  logic [15:0] baudDivisor;
  int mismatches = 0;
  int nTests = 0;
  int rxT [3][4] = '{'{1, 4, 8, 14}, '{8, 16, 24, 28}, '{8, 16, 56, 60}};
  int txT [3][4] = '{'{1, 1, 1, 1}, '{16, 8, 24, 30}, '{8, 16, 32, 56}};
  always #12.5 ref_clk = ~ref_clk;
  ulc_top dut_u (.ref_clk, .reset_n, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData, .txCount, .txLoad, .rxFlowStop, .ctsIn_n,
    .dsrIn_n, .dtrOut_n, .rtsOut_n, .txShiftData, .txSerial, .rxFifoClear,
    .txFifoClear, .fifoEnable, .txRequest, .rxTrigLevel, .txTrigLevel,
    .dataBits, .stopHalfBits, .parityEnable, .parityMode, .baudDivisor);
  ulc_modem_model model_u (.ref_clk, .ctsLevel, .dsrLevel(1'b0), .ctsIn_n,
    .dsrIn_n);
  // Wide enough for the widest packed compare (19 bits)
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    nTests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : wr
  // Read data only stands one cycle, so grab it mid-cycle
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(negedge ref_clk);
    d = regRdData;
  endtask : rd
  task automatic txStep(input logic [6:0] c, input logic l, input logic e);
    @(posedge ref_clk);
    txCount <= c;
    txLoad <= l;
    @(posedge ref_clk);
    txLoad <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(txRequest, e);
  endtask : txStep
  task automatic give_verdict;
    $display("%0d compares, %0d mismatches", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    chk({dtrOut_n, rtsOut_n, fifoEnable, baudDivisor}, 19'h60001);
    chk({dataBits, stopHalfBits, rxTrigLevel}, {4'h5, 3'h2, 7'h1});
    for (int i = 0; i < 64; i++) begin
      wr(ulc_pkg::OFS_LINE, 8'(i));
      rd(ulc_pkg::OFS_LINE);
      chk(d, i);
      chk(dataBits, 5 + i % 4);
      chk(stopHalfBits, i[2] ? (i % 4 ? 4 : 3) : 2);
      chk(parityEnable, i[3]);
      chk(parityMode, i[3] ? (i[5] ? 2 + i[4] : 1) : 0);
    end
    wr(ulc_pkg::OFS_LINE, 8'h40);
    repeat (4) @(negedge ref_clk);
    chk(txSerial, 0);
    wr(ulc_pkg::OFS_LINE, 8'h80);
    wr(ulc_pkg::OFS_DATA, 8'h34);
    wr(ulc_pkg::OFS_DIV_HIGH, 8'h12);
    wr(ulc_pkg::OFS_LINE, 8'h00);
    wr(ulc_pkg::OFS_DATA, 8'h77);
    @(negedge ref_clk);
    chk({txSerial, baudDivisor}, 17'h11234);
    rd(4'hf);
    chk(d, 0);
    $display("test line format done");
    wr(ulc_pkg::OFS_STATUS, 8'h07);
    @(negedge ref_clk);
    chk({fifoEnable, rxFifoClear, txFifoClear}, 3'b111);
    @(negedge ref_clk);
    chk({rxFifoClear, txFifoClear}, 0);
    rd(ulc_pkg::OFS_STATUS);
    chk(d, 8'hc1);
    wr(ulc_pkg::OFS_STATUS, 8'h0e);
    rd(ulc_pkg::OFS_STATUS);
    chk({fifoEnable, rxFifoClear, txFifoClear, d}, 11'h001);
    wr(ulc_pkg::OFS_STATUS, 8'h09);
    rd(ulc_pkg::OFS_FORMAT);
    chk(d, 8'h09);
    wr(ulc_pkg::OFS_ENH, 8'h10);
    for (int t = 0; t < 3; t++) begin
      for (int c = 0; c < 4; c++) begin
        wr(ulc_pkg::OFS_TABLE, 8'(t << 6));
        wr(ulc_pkg::OFS_STATUS, 8'(c * 80 + 1));
        @(negedge ref_clk);
        chk({rxTrigLevel, txTrigLevel}, {7'(rxT[t][c]), 7'(txT[t][c])});
      end
    end
    wr(ulc_pkg::OFS_PROG_RX, 8'h21);
    wr(ulc_pkg::OFS_PROG_TX, 8'h13);
    wr(ulc_pkg::OFS_TABLE, 8'hc0);
    @(negedge ref_clk);
    chk({rxTrigLevel, txTrigLevel}, {7'h21, 7'h13});
    // Clearing enhanced mode must freeze the transmit code
    wr(ulc_pkg::OFS_TABLE, 8'h40);
    wr(ulc_pkg::OFS_ENH, 8'h00);
    wr(ulc_pkg::OFS_STATUS, 8'h11);
    @(negedge ref_clk);
    chk({rxTrigLevel, txTrigLevel}, {7'd8, 7'd30});
    txStep(40, 1, 0);
    txStep(29, 0, 1);
    txStep(20, 1, 0);
    txStep(10, 0, 0);
    txStep(0, 0, 1);
    $display("test fifo control done");
    wr(ulc_pkg::OFS_MODEM, 8'h03);
    @(negedge ref_clk);
    chk({dtrOut_n, rtsOut_n}, 2'b00);
    wr(ulc_pkg::OFS_ENH, 8'h40);
    wr(ulc_pkg::OFS_MODEM, 8'h07);
    rxFlowStop <= 1'b1;
    @(negedge ref_clk);
    chk({dtrOut_n, rtsOut_n}, 2'b10);
    wr(ulc_pkg::OFS_MODEM, 8'h03);
    @(negedge ref_clk);
    chk({dtrOut_n, rtsOut_n}, 2'b01);
    wr(ulc_pkg::OFS_ENH, 8'h90);
    rxFlowStop <= 1'b0;
    wr(ulc_pkg::OFS_MODEM, 8'h00);
    rd(ulc_pkg::OFS_STATUS);
    @(posedge ref_clk);
    ctsLevel <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(ulc_pkg::OFS_STATUS);
    chk(d, 8'he0);
    rd(ulc_pkg::OFS_STATUS);
    chk(d, 8'hc1);
    wr(ulc_pkg::OFS_ENH, 8'h50);
    wr(ulc_pkg::OFS_MODEM, 8'h02);
    rd(ulc_pkg::OFS_STATUS);
    wr(ulc_pkg::OFS_MODEM, 8'h00);
    rd(ulc_pkg::OFS_STATUS);
    chk(d, 8'he0);
    $display("test modem done");
    give_verdict();
  end
  initial begin
    repeat (4000) @(posedge ref_clk);
    mismatches++;
    give_verdict();
  end
endmodule : test_uart_fifo_line_modem_control

// ---- tb/ulc_modem_model.sv ----
// Remote modem model driving the handshake inputs
`timescale 1ns/100ps
module ulc_modem_model (
  // Clock
  input wire logic ref_clk,
  // Requested levels
  input wire logic ctsLevel,
  input wire logic dsrLevel,
  // Pins toward the block
  output logic ctsIn_n = 1'b0,
  output logic dsrIn_n = 1'b0
);
  // Pins move on edges only, so the block sees clean levels
  always @(posedge ref_clk) begin
    ctsIn_n <= ctsLevel;
    dsrIn_n <= dsrLevel;
  end
endmodule : ulc_modem_model

// ---- tb/ulc_top_props.sv ----
// Port-level checker for the UART control block
`timescale 1ns/100ps
module ulc_top_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [ulc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // Line side and data path controls
  input wire logic rxFlowStop,
  input wire logic dtrOut_n,
  input wire logic rtsOut_n,
  input wire logic txSerial,
  input wire logic rxFifoClear,
  input wire logic txFifoClear,
  input wire logic fifoEnable,
  input wire logic [3:0] dataBits,
  input wire logic [2:0] stopHalfBits
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence fcrWr;
    regWrite && regAddr == ulc_pkg::OFS_STATUS;
  endsequence
  sequence lineWr;
    regWrite && regAddr == ulc_pkg::OFS_LINE;
  endsequence
  sequence modemWr;
    regWrite && regAddr == ulc_pkg::OFS_MODEM;
  endsequence
  clear_pair_a: assert property (
    fcrWr ##0 regWrData[0] |=> rxFifoClear == $past(regWrData[1])
    && txFifoClear == $past(regWrData[2])) else $error("clear pulse");
  clear_cause_a: assert property (
    rxFifoClear || txFifoClear |-> $past(regWrite && regWrData[0]))
    else $error("stray clear");
  fifo_refused_a: assert property (
    fcrWr ##0 !regWrData[0] |=> !fifoEnable) else $error("fifo on");
  status_en_a: assert property (
    regRead && regAddr == ulc_pkg::OFS_STATUS
    |=> regRdData[7:6] == {2{$past(fifoEnable)}}) else $error("status");
  break_low_a: assert property (
    lineWr ##0 regWrData[6] |=> !txSerial) else $error("break");
  word_len_a: assert property (
    lineWr |=> dataBits == 4'h5 + 4'($past(regWrData[1:0])))
    else $error("word length");
  stop_len_a: assert property (
    lineWr |=> stopHalfBits == (!$past(regWrData[2]) ? 3'h2
    : ($past(regWrData[1:0]) == 2'h0 ? 3'h3 : 3'h4))) else $error("stop");
  dtr_force_a: assert property (
    modemWr ##1 !rxFlowStop |-> dtrOut_n != $past(regWrData[0]))
    else $error("dtr level");
  rts_force_a: assert property (
    modemWr ##1 !rxFlowStop |-> rtsOut_n != $past(regWrData[1]))
    else $error("rts level");
endmodule : ulc_top_props
bind ulc_top ulc_top_props chk_u (.ref_clk, .reset_n, .regAddr,
  .regWrData, .regWrite, .regRead, .regRdData, .rxFlowStop, .dtrOut_n,
  .rtsOut_n, .txSerial, .rxFifoClear, .txFifoClear, .fifoEnable,
  .dataBits, .stopHalfBits);
